//--- pkg/awct_defines.svh
// Register offsets, field positions and reset values of the result checker
`ifndef AWCT_DEFINES_SVH
`define AWCT_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define AWCT_OFF_CTRL     8'h00
`define AWCT_OFF_LOWER    8'h04
`define AWCT_OFF_UPPER    8'h08
`define AWCT_OFF_FLAGS    8'h0c
`define AWCT_OFF_CLEAR    8'h10
`define AWCT_OFF_MASK     8'h14
`define AWCT_OFF_MASKED   8'h18
`define AWCT_OFF_CHAN     8'h40
`define AWCT_OFF_RESULT   8'h80

// ****************************************************************
// Field positions
// ****************************************************************
`define AWCT_CTRL_SWTRIG  0
`define AWCT_CTRL_FMT_LO  1
`define AWCT_CTRL_RES_LO  3
`define AWCT_CHAN_WCEN    0
`define AWCT_FLG_BELOW    0
`define AWCT_FLG_ABOVE    1
`define AWCT_FLG_INSIDE   2
`define AWCT_FLG_TOVF     3

// ****************************************************************
// Reset values
// ****************************************************************
`define AWCT_RST_LOWER    12'h000
`define AWCT_RST_UPPER    12'hfff
`define AWCT_RST_FLAGS    4'h0
`define AWCT_RST_MASK     4'h0
`define AWCT_RST_SEL      2'h0

`endif

//--- pkg/awct_pkg.sv
// Types shared by the result checker files
package awct_pkg;

  // ****************************************************************
  // Data types
  // ****************************************************************
  typedef logic [11:0] awct_result_t;
  typedef logic [3:0]  awct_chan_t;
  typedef logic [3:0]  awct_flags_t;
  typedef logic [1:0]  awct_sel_t;

endpackage

//--- hdl/awct_window_cmp.sv
// Single window comparator with registered outcome pulses
`timescale 1ns/1ps

module awct_window_cmp (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  // Value under test and thresholds
  input  wire logic               cmp_en_i,
  input  wire awct_pkg::awct_result_t value_i,
  input  wire awct_pkg::awct_result_t lower_i,
  input  wire awct_pkg::awct_result_t upper_i,
  // Outcome pulses
  output logic                    below_o,
  output logic                    above_o,
  output logic                    inside_o
);

  logic lt_lower;
  logic gt_upper;

  // Strict compares; equality counts as inside
  assign lt_lower = value_i < lower_i;                  // see RULE4
  assign gt_upper = value_i > upper_i;                  // see RULE5

  // Outcome pulses, one cycle per compared result
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      below_o  <= 1'b0;
      above_o  <= 1'b0;
      inside_o <= 1'b0;
    end else begin
      below_o  <= cmp_en_i & lt_lower;                  // see RULE4
      above_o  <= cmp_en_i & gt_upper;                  // see RULE5
      inside_o <= cmp_en_i & ~lt_lower & ~gt_upper;     // see RULE8
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_inside_eq;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      cmp_en_i && (value_i == lower_i || value_i == upper_i) && lower_i <= upper_i
      |=> inside_o && !below_o && !above_o;
  endproperty
  a_inside_eq: assert property (p_inside_eq) else $error("equal result not inside"); // see RULE8

  property p_outcome_set;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      cmp_en_i && lower_i <= upper_i |=> $onehot({below_o, above_o, inside_o});
  endproperty
  a_outcome_set: assert property (p_outcome_set) else $error("not one outcome"); // see RULE3

  property p_idle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !cmp_en_i |=> !below_o && !above_o && !inside_o;
  endproperty
  a_idle: assert property (p_idle) else $error("outcome without compare"); // see RULE9

endmodule // awct_window_cmp

//--- hdl/awct_top.sv
// Result checker: window compare, trigger overflow and flag registers
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "awct_defines.svh"

// Overview of operation
// RULE1 - One window comparator serves the converter, thresholds set by software.
// RULE2 - Compared value is the result as written into result memory.
// RULE3 - Comparator yields three separate flagged outcomes per compared result.
// RULE4 - Result strictly below lower threshold sets the below-window flag.
// RULE5 - Result strictly above upper threshold sets the above-window flag.
// RULE6 - Trigger arriving while sampling or converting sets trigger overflow flag.
// RULE7 - Trigger overflow flag raises interrupt when enabled in the mask.
// RULE8 - Result between thresholds, equality included, sets the inside-window flag.
// RULE9 - Thresholds shared by all channels; compare enabled per channel control word.
// RULE10 - Format or resolution change leaves thresholds untouched; software reprograms.
// RULE11 - Flags stay set until software clears them; recurrence keeps them set.
module awct_top (
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // Register port
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic [31:0]                 reg_rdata_o,
  // Converter side
  input  wire logic                   trig_evt_i,
  input  wire logic                   conv_busy_i,
  input  wire logic                   res_valid_i,
  input  wire awct_pkg::awct_result_t res_data_i,
  input  wire awct_pkg::awct_chan_t   res_chan_i,
  output logic                        conv_start_o,
  output awct_pkg::awct_sel_t         result_format_select_o,
  output awct_pkg::awct_sel_t         result_resolution_select_o,
  // Interrupt request
  output logic                        irq_o
);

  awct_pkg::awct_result_t window_lower_threshold_q;
  awct_pkg::awct_result_t window_upper_threshold_q;
  awct_pkg::awct_flags_t  flags_q;
  awct_pkg::awct_flags_t  flags_d;
  awct_pkg::awct_flags_t  flag_set;
  awct_pkg::awct_flags_t  flag_clr;
  awct_pkg::awct_flags_t  mask_q;
  logic                   soft_trig_q;
  logic                   trigger;
  logic                   chan_en;
  logic                   cmp_below;
  logic                   cmp_above;
  logic                   cmp_inside;
  logic [15:0]            window_compare_channel_enable_q;
  awct_pkg::awct_result_t conversion_result_memory [16];

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic in_block(input logic [7:0] addr, input logic [7:0] base);
    in_block = (addr[7:6] == base[7:6]) && (addr[1:0] == 2'h0);
  endfunction

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Thresholds have their own offsets; a format write never reaches them
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      window_lower_threshold_q <= `AWCT_RST_LOWER;
      window_upper_threshold_q <= `AWCT_RST_UPPER;
    end else if (reg_wr_i && reg_addr_i == `AWCT_OFF_LOWER) begin
      window_lower_threshold_q <= reg_wdata_i[11:0];     // see RULE1
    end else if (reg_wr_i && reg_addr_i == `AWCT_OFF_UPPER) begin
      window_upper_threshold_q <= reg_wdata_i[11:0];     // see RULE1
    end
  end

  // Format and resolution selects, passed on to the converter
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      result_format_select_o     <= `AWCT_RST_SEL;
      result_resolution_select_o <= `AWCT_RST_SEL;
    end else if (reg_wr_i && reg_addr_i == `AWCT_OFF_CTRL) begin
      result_format_select_o     <= reg_wdata_i[`AWCT_CTRL_FMT_LO +: 2]; // see RULE10
      result_resolution_select_o <= reg_wdata_i[`AWCT_CTRL_RES_LO +: 2]; // see RULE10
    end
  end

  // Software trigger is a one-cycle pulse from a control write
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      soft_trig_q <= 1'b0;
    end else begin
      soft_trig_q <= reg_wr_i && reg_addr_i == `AWCT_OFF_CTRL
                     && reg_wdata_i[`AWCT_CTRL_SWTRIG];
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mask_q <= `AWCT_RST_MASK;
    end else if (reg_wr_i && reg_addr_i == `AWCT_OFF_MASK) begin
      mask_q <= reg_wdata_i[3:0];
    end
  end

  // Per-channel control words, compare enable bit only
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      window_compare_channel_enable_q <= 16'h0000;
    end else if (reg_wr_i && in_block(reg_addr_i, `AWCT_OFF_CHAN)) begin
      window_compare_channel_enable_q[reg_addr_i[5:2]] <= reg_wdata_i[`AWCT_CHAN_WCEN]; // see RULE9
    end
  end

  // ****************************************************************
  // Trigger handling
  // ****************************************************************
  assign trigger = trig_evt_i | soft_trig_q;

  // A trigger only starts the converter when it is idle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= trigger & ~conv_busy_i;
    end
  end

  // ****************************************************************
  // Result memory and window compare
  // ****************************************************************
  // Results land here; no reset, software reads only written slots
  always_ff @(posedge ref_clk_i) begin
    if (res_valid_i) begin
      conversion_result_memory[res_chan_i] <= res_data_i; // see RULE2
    end
  end

  assign chan_en = res_valid_i & window_compare_channel_enable_q[res_chan_i]; // see RULE9

  // The one comparator, fed the value being written
  awct_window_cmp u_cmp (                                 // see RULE1
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .cmp_en_i  (chan_en),
    .value_i   (res_data_i),                              // see RULE2
    .lower_i   (window_lower_threshold_q),
    .upper_i   (window_upper_threshold_q),
    .below_o   (cmp_below),
    .above_o   (cmp_above),
    .inside_o  (cmp_inside)
  );

  // ****************************************************************
  // Sticky flags
  // ****************************************************************
  assign flag_set = {trigger & conv_busy_i, cmp_inside, cmp_above, cmp_below}; // see RULE3
  assign flag_clr = (reg_wr_i && reg_addr_i == `AWCT_OFF_CLEAR) ? reg_wdata_i[3:0] : 4'h0;
  // Set beats clear so an event in the clearing cycle is kept
  assign flags_d  = (flags_q & ~flag_clr) | flag_set;    // see RULE11

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flags_q <= `AWCT_RST_FLAGS;
    end else begin
      flags_q <= flags_d;                                 // see RULE6
    end
  end

  // Interrupt is registered from the next flag value, so it rises in the same cycle as the masked flags
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags_d & mask_q);                      // see RULE7
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (in_block(reg_addr_i, `AWCT_OFF_CHAN)) begin
      reg_rdata_o <= {31'h0, window_compare_channel_enable_q[reg_addr_i[5:2]]};
    end else if (in_block(reg_addr_i, `AWCT_OFF_RESULT)) begin
      reg_rdata_o <= {20'h0, conversion_result_memory[reg_addr_i[5:2]]};
    end else begin
      case (reg_addr_i)
        `AWCT_OFF_CTRL:   reg_rdata_o <= {27'h0, result_resolution_select_o,
                                          result_format_select_o, 1'b0};
        `AWCT_OFF_LOWER:  reg_rdata_o <= {20'h0, window_lower_threshold_q};
        `AWCT_OFF_UPPER:  reg_rdata_o <= {20'h0, window_upper_threshold_q};
        `AWCT_OFF_FLAGS:  reg_rdata_o <= {28'h0, flags_q};
        `AWCT_OFF_MASK:   reg_rdata_o <= {28'h0, mask_q};
        `AWCT_OFF_MASKED: reg_rdata_o <= {28'h0, flags_q & mask_q};
        default:          reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_tovf_set;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      trigger && conv_busy_i |=> flags_q[`AWCT_FLG_TOVF] && !conv_start_o;
  endproperty
  a_tovf_set: assert property (p_tovf_set) else $error("overflow flag missed"); // see RULE6

  property p_tovf_irq;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      trigger && conv_busy_i && mask_q[`AWCT_FLG_TOVF] |=> irq_o;
  endproperty
  a_tovf_irq: assert property (p_tovf_irq) else $error("overflow irq missed"); // see RULE7

  property p_below;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      chan_en && res_data_i < window_lower_threshold_q |-> ##2 flags_q[`AWCT_FLG_BELOW];
  endproperty
  a_below: assert property (p_below) else $error("below flag missed"); // see RULE4

  property p_above;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      chan_en && res_data_i > window_upper_threshold_q |-> ##2 flags_q[`AWCT_FLG_ABOVE];
  endproperty
  a_above: assert property (p_above) else $error("above flag missed"); // see RULE5

  property p_sticky;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      flags_q[`AWCT_FLG_INSIDE] && !(reg_wr_i && reg_addr_i == `AWCT_OFF_CLEAR)
      |=> flags_q[`AWCT_FLG_INSIDE];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped by itself"); // see RULE11

  property p_thr_kept;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      reg_wr_i && reg_addr_i == `AWCT_OFF_CTRL
      |=> $stable(window_lower_threshold_q) && $stable(window_upper_threshold_q);
  endproperty
  a_thr_kept: assert property (p_thr_kept) else $error("threshold moved on ctrl write"); // see RULE10

  property p_mem_written;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      res_valid_i |=> conversion_result_memory[$past(res_chan_i)] == $past(res_data_i);
  endproperty
  a_mem_written: assert property (p_mem_written) else $error("result not stored"); // see RULE2

  property p_chan_off;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      res_valid_i && !window_compare_channel_enable_q[res_chan_i] && flags_q[2:0] == 3'h0
      && !cmp_below && !cmp_above && !cmp_inside
      |-> ##1 (!cmp_below && !cmp_above && !cmp_inside) ##1 flags_q[2:0] == 3'h0;
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("disabled channel compared"); // see RULE9

  // An event in the clearing cycle must survive the clear
  property p_set_wins;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      flag_set != 4'h0 |=> (flags_q & $past(flag_set)) == $past(flag_set);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag event lost to clear"); // see RULE11

  // Read data stands only in the cycle after a read strobe
  property p_rdata_idle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !reg_rd_i |=> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

endmodule // awct_top

//--- test/awct_conv_model.sv
// Behavioural converter model: answers start pulses with one result
`timescale 1ns/1ps

module awct_conv_model #(
  parameter int BUSY = 6
) (
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // Start request and next sample to hand back
  input  wire logic                   start_i,
  input  wire awct_pkg::awct_result_t data_i,
  input  wire awct_pkg::awct_chan_t   chan_i,
  // Converter status and result write
  output logic                        busy_o,
  output logic                        valid_o,
  output awct_pkg::awct_result_t      data_o,
  output awct_pkg::awct_chan_t        chan_o
);
  int cnt_q;

  // Busy countdown; data toggles outside the write so stale values never match
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_q   <= 0;
      valid_o <= 1'b0;
      data_o  <= 12'h000;
      chan_o  <= 4'h0;
    end else begin
      valid_o <= 1'b0;
      data_o  <= ~data_o;
      if (start_i) begin
        cnt_q <= BUSY;
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
        if (cnt_q == 1) begin
          valid_o <= 1'b1;
          data_o  <= data_i;
          chan_o  <= chan_i;
        end
      end
    end
  end

  assign busy_o = (cnt_q != 0);
endmodule // awct_conv_model

//--- test/awct_top_tb.sv
// Self-checking bench of the result checker
`timescale 1ns/1ps
`include "awct_defines.svh"

module awct_top_tb;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, trig = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic        start, busy, valid, irq;
  logic [11:0] rdat, mdata = 12'h000, d;
  logic [11:0] lo = 12'h100, hi = 12'h800;
  logic [3:0]  rchan, mchan = 4'h0;
  logic [1:0]  fmt, res;
  int          seed = 32'h5b10, n_mismatch = 0, checks = 0, cyc = 0;

  // ****************************************************************
  // Clock, design and converter model
  // ****************************************************************
  always #5 clk = ~clk;

  awct_top i_awct_top (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .trig_evt_i(trig), .conv_busy_i(busy), .res_valid_i(valid), .res_data_i(rdat),
    .res_chan_i(rchan), .conv_start_o(start), .result_format_select_o(fmt),
    .result_resolution_select_o(res), .irq_o(irq));

  awct_conv_model i_awct_conv_model (.ref_clk_i(clk), .rst_n_i(rst_n), .start_i(start),
    .data_i(mdata), .chan_i(mchan), .busy_o(busy), .valid_o(valid), .data_o(rdat),
    .chan_o(rchan));

  // Hang guard: the whole run needs well under 3000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end

  // ****************************************************************
  // Tasks and expectation
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Data stands only in the cycle after the strobe is taken
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic pulse_trig;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
  endtask

  // Waits for the result write, then for the flag and interrupt to land
  task automatic wait_res;
    int k;
    k = 0;
    while (valid !== 1'b1 && k < 50) begin
      @(posedge clk);
      #1 k++;
    end
    chk("result write", 32'h1, {31'h0, valid});
    repeat (3) @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] exp_flags(logic [11:0] v, logic en);
    return {28'h0, 1'b0, en && v >= lo && v <= hi, en && v > hi, en && v < lo};
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`AWCT_OFF_LOWER, rv); chk("lower reset", 32'h0, rv);
    rd_reg(`AWCT_OFF_UPPER, rv); chk("upper reset", 32'hfff, rv);
    rd_reg(`AWCT_OFF_FLAGS, rv); chk("flags reset", 32'h0, rv);
    rd_reg(8'hfc, rv); chk("unmapped", 32'h0, rv);
    wr_reg(`AWCT_OFF_LOWER, {20'h0, lo});
    wr_reg(`AWCT_OFF_UPPER, {20'h0, hi});
    for (int c = 0; c < 15; c++) wr_reg(`AWCT_OFF_CHAN + 8'(4 * c), 32'h1);
    // Threshold corners first, then random samples; slot 15 stays disabled
    for (int i = 0; i < 24; i++) begin
      case (i)
        0: d = 12'h0ff; 1: d = 12'h100; 2: d = 12'h800;
        3: d = 12'h801; 4: d = 12'h000; 5: d = 12'hfff;
        default: d = 12'($random(seed));
      endcase
      mdata <= d; mchan <= 4'(i);
      wr_reg(`AWCT_OFF_CLEAR, 32'hf);
      pulse_trig;
      wait_res;
      rd_reg(`AWCT_OFF_FLAGS, rv); chk("flags", exp_flags(d, i % 16 != 15), rv);
      rd_reg(`AWCT_OFF_RESULT + 8'(4 * (i % 16)), rv); chk("slot", {20'h0, d}, rv);
    end
    // Back-to-back triggers: the second lands while busy
    wr_reg(`AWCT_OFF_CLEAR, 32'hf);
    wr_reg(`AWCT_OFF_MASK, 32'h8);
    mdata <= lo; mchan <= 4'h0;
    pulse_trig;
    pulse_trig;
    wait_res;
    chk("irq", 32'h1, {31'h0, irq});
    rd_reg(`AWCT_OFF_FLAGS, rv); chk("flags ovf", 32'hc, rv);
    rd_reg(`AWCT_OFF_MASKED, rv); chk("masked", 32'h8, rv);
    pulse_trig;
    pulse_trig;
    wait_res;
    rd_reg(`AWCT_OFF_FLAGS, rv); chk("flags again", 32'hc, rv);
    wr_reg(`AWCT_OFF_CLEAR, 32'h8);
    rd_reg(`AWCT_OFF_FLAGS, rv); chk("flags w1c", 32'h4, rv);
    wr_reg(`AWCT_OFF_MASK, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    // Soft trigger together with a format and resolution change
    wr_reg(`AWCT_OFF_CLEAR, 32'hf);
    mdata <= hi + 12'h001;
    wr_reg(`AWCT_OFF_CTRL, 32'hd);
    chk("format", 32'h2, {30'h0, fmt});
    chk("resolution", 32'h1, {30'h0, res});
    wait_res;
    rd_reg(`AWCT_OFF_FLAGS, rv); chk("flags soft", 32'h2, rv);
    rd_reg(`AWCT_OFF_LOWER, rv); chk("lower kept", {20'h0, lo}, rv);
    rd_reg(`AWCT_OFF_UPPER, rv); chk("upper kept", {20'h0, hi}, rv);
    end_sim;
  end
endmodule // awct_top_tb
